// ---- rtl/sfb_spi.sv ----
`timescale 1ns/1ps
module sfb_fifo import sfb_pkg::*; #(
   parameter int WIDTH = 32,
   parameter int DEPTH = SFB_FIFO_DEPTH
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int PW = $clog2(DEPTH);
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [PW-1:0] wp;
      logic [PW-1:0] rp;
      logic [PW:0] cnt;
   } sfb_fifo_st_t;
   sfb_fifo_st_t r, n;
   logic push, pop;
   assign in_ready = r.cnt != (PW+1)'(DEPTH);
   assign out_valid = r.cnt != '0;
   assign out_data = r.mem[r.rp];
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;
   always_comb
   begin
      n = r;
      if (push)
      begin
         n.mem[r.wp] = in_data;
         n.wp = (r.wp == PW'(DEPTH - 1)) ? '0 : r.wp + 1'b1;
      end
      if (pop)
         n.rp = (r.rp == PW'(DEPTH - 1)) ? '0 : r.rp + 1'b1;
      n.cnt = r.cnt + (PW+1)'(push) - (PW+1)'(pop);
   end
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
         r <= '0;
      else
         r <= n;
   end
endmodule // sfb_fifo

////////////////////////////////////////////////////////////////////////////////
// Functional notes
// - single-bit read data changes on the output pin after serial clock falls
// - dual-input program samples the output pin too on rising clock
// - instruction, address and program bits sampled from input pin on rising clock
// - dual-output read drives the input pin as well on falling clock
// - select high means deselected and output pin floats
// - standby only when deselected and no internal cycle runs
// - no instruction accepted until select has fallen once after reset
// - hold pauses transfer, keeping selection and all transfer state
// - during hold pins float, data and clock ignored
// - 128 sectors of 16 subsectors, 2048 subsectors for erase
// - erase one subsector, one sector, or whole array
// - page program takes one to 256 bytes per sequence
// - write protection granularity is one 64-Kbyte sector
// - 64-byte one-time area with own read and program instructions
// - once locked the one-time area is read-only until reset, which unlocks it and sets every byte back to all ones
// - dual read and dual program move two bits per clock
// - bulk erase runs fast whenever high program voltage is present
// - only clock modes 0 and 3 are used
module sfb_spi import sfb_pkg::*; (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // serial pins
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic hold_n,
   input wire logic vpp_high,
   input wire logic serial_in_pin_in,
   output logic serial_in_pin_out,
   output logic serial_in_pin_oe_n,
   input wire logic serial_out_pin_in,
   output logic serial_out_pin_out,
   output logic serial_out_pin_oe_n,
   // array core status
   input wire logic core_busy,
   input wire logic [SFB_SECTORS-1:0] sector_protect,
   output logic standby,
   // array read
   output logic [SFB_ADDR_W-1:0] mem_rd_addr,
   input wire logic [7:0] mem_rd_data,
   // erase request
   output logic erase_req,
   output logic [1:0] erase_kind,
   output logic [$clog2(SFB_SUBSECTORS)-1:0] erase_subsector,
   output logic erase_fast,
   // program stream
   output logic prog_valid,
   input wire logic prog_ready,
   output logic [SFB_ADDR_W-1:0] prog_addr,
   output logic [7:0] prog_data,
   output logic prog_commit,
   output logic prog_overrun
);
   typedef struct packed {
      logic [5:0] s1;
      logic [5:0] s2;
      logic sclk_d;
      logic csn_d;
      logic armed;
      logic wel;
      sfb_state_t st;
      logic [7:0] cmd;
      logic [7:0] sr;
      logic [4:0] bits;
      logic [SFB_ADDR_W-1:0] addr;
      logic [2:0] pos;
      logic drv;
      logic [8:0] pcount;
      logic otp_locked;
      logic [SFB_OTP_BYTES-1:0][7:0] otp;
      logic so_out;
      logic si_out;
      logic so_oe_n;
      logic si_oe_n;
      logic [SFB_ADDR_W-1:0] rd_addr;
      logic erase_req;
      logic [1:0] erase_kind;
      logic [$clog2(SFB_SUBSECTORS)-1:0] erase_sub;
      logic erase_fast;
      logic commit;
      logic overrun;
      logic standby;
   } sfb_st_t;
   sfb_st_t r, n;

   ////////////////////////////////////////////////////////////////////////////
   logic csn, holdact, rise_ok, fall_ok, wr_ok, dual_in, sect_prot;
   logic [7:0] byte1, byte2, otp_byte, rbyte;
   logic [SFB_ADDR_W-1:0] addr_in;
   logic [2:0] pos1;
   logic [4:0] step;
   logic fifo_push, fifo_in_ready;

   // only the second sync stage is read
   assign csn = r.s2[1];
   assign holdact = ~r.s2[2] & ~csn;
   // only edges count, so both idle levels work
   assign rise_ok = r.s2[0] & ~r.sclk_d & ~csn & ~r.csn_d & ~holdact;
   assign fall_ok = ~r.s2[0] & r.sclk_d & ~csn & ~r.csn_d & ~holdact;
   assign byte1 = {r.sr[6:0], r.s2[3]};
   assign byte2 = {r.sr[5:0], r.s2[4], r.s2[3]};
   assign addr_in = {r.addr[SFB_ADDR_W-2:0], r.s2[3]};
   assign sect_prot = sector_protect[addr_in[SFB_MEM_TOP:SFB_SECT_LSB]];
   assign wr_ok = r.wel & ~core_busy;
   assign dual_in = r.cmd == SFB_OP_DUAL_PG;
   assign step = dual_in ? 5'h2 : 5'h1;
   assign otp_byte = r.addr[6] ? {7'h0, ~r.otp_locked} : r.otp[r.addr[5:0]];
   assign rbyte = (r.cmd == SFB_OP_OTP_RD) ? otp_byte : mem_rd_data;
   assign pos1 = r.pos + 3'h1;

   always_comb
   begin
      n = r;
      fifo_push = 1'b0;
      n.s1 = {vpp_high, serial_out_pin_in, serial_in_pin_in, hold_n, cs_n, sclk};
      n.s2 = r.s1;
      n.sclk_d = r.s2[0];
      n.csn_d = r.s2[1];
      n.erase_req = 1'b0;
      n.commit = 1'b0;
      n.overrun = 1'b0;
      if (csn)
      begin
         // conclude only on a whole byte; a partial byte drops the write enable, erase or commit, but one-time bytes already written stay
         if (!r.csn_d && r.bits == 5'h0)
         begin
            if (r.st == ST_DONE && r.cmd == SFB_OP_WR_EN)
               n.wel = 1'b1;
            if (r.st == ST_DONE && (r.cmd == SFB_OP_SSE || r.cmd == SFB_OP_SE ||
               r.cmd == SFB_OP_BE))
            begin
               n.erase_req = 1'b1;
               n.wel = 1'b0;
               n.erase_kind = (r.cmd == SFB_OP_SSE) ? SFB_ER_SUB :
                  (r.cmd == SFB_OP_SE) ? SFB_ER_SECT : SFB_ER_BULK;
               n.erase_sub = r.addr[SFB_MEM_TOP:SFB_SUB_LSB];
               if (r.cmd != SFB_OP_SSE)
                  n.erase_sub[3:0] = 4'h0;
               n.erase_fast = (r.cmd == SFB_OP_BE) & r.s2[5];
            end
            if (r.st == ST_WDATA && r.cmd != SFB_OP_OTP_PG && r.pcount != 9'h0)
            begin
               n.commit = 1'b1;
               n.wel = 1'b0;
            end
            if (r.st == ST_WDATA && r.cmd == SFB_OP_OTP_PG)
               n.wel = 1'b0;
         end
         // a seen high makes the next fall a real one
         n.armed = 1'b1;
         n.st = ST_IDLE;
         n.bits = 5'h0;
         n.pos = 3'h0;
         n.drv = 1'b0;
      end
      else if (r.csn_d)
      begin
         if (r.armed)
            n.st = ST_CMD;
         n.cmd = SFB_OP_NONE;
         n.pcount = 9'h0;
      end
      else if (rise_ok)
      begin
         unique case (r.st)
            ST_CMD:
            begin
               n.sr = byte1;
               n.bits = r.bits + 5'h1;
               if (r.bits == 5'h7)
               begin
                  n.bits = 5'h0;
                  n.cmd = byte1;
                  n.st = ST_DONE;
                  case (byte1)
                     SFB_OP_READ, SFB_OP_DUAL_RD, SFB_OP_OTP_RD:
                        n.st = ST_ADDR;
                     SFB_OP_PP, SFB_OP_DUAL_PG, SFB_OP_OTP_PG, SFB_OP_SSE, SFB_OP_SE:
                        if (wr_ok)
                           n.st = ST_ADDR;
                        else
                           n.cmd = SFB_OP_NONE;
                     SFB_OP_BE:
                        if (!wr_ok || |sector_protect)
                           n.cmd = SFB_OP_NONE;
                     SFB_OP_WR_EN:
                        n.st = ST_DONE;
                     default:
                        n.cmd = SFB_OP_NONE;
                  endcase
               end
            end
            ST_ADDR:
            begin
               n.addr = addr_in;
               n.bits = r.bits + 5'h1;
               if (r.bits == 5'(SFB_ADDR_W - 1))
               begin
                  n.bits = 5'h0;
                  n.rd_addr = addr_in;
                  n.st = ST_DONE;
                  case (r.cmd)
                     SFB_OP_READ:
                        n.st = ST_RDATA;
                     SFB_OP_DUAL_RD, SFB_OP_OTP_RD:
                        n.st = ST_DUMMY;
                     SFB_OP_OTP_PG:
                        n.st = ST_WDATA;
                     SFB_OP_PP, SFB_OP_DUAL_PG, SFB_OP_SSE, SFB_OP_SE:
                        if (sect_prot)
                           n.cmd = SFB_OP_NONE;
                        else if (r.cmd == SFB_OP_PP || r.cmd == SFB_OP_DUAL_PG)
                           n.st = ST_WDATA;
                     default:
                        n.cmd = SFB_OP_NONE;
                  endcase
               end
            end
            ST_DUMMY:
            begin
               n.bits = r.bits + 5'h1;
               if (r.bits == 5'h7)
               begin
                  n.bits = 5'h0;
                  n.st = ST_RDATA;
               end
            end
            ST_WDATA:
            begin
               n.sr = dual_in ? byte2 : byte1;
               n.bits = r.bits + step;
               if (n.bits == 5'h8)
               begin
                  n.bits = 5'h0;
                  if (r.cmd == SFB_OP_OTP_PG)
                  begin
                     // lock byte sits just above the 64 data bytes
                     if (!r.otp_locked)
                     begin
                        if (r.addr[6])
                           n.otp_locked = ~n.sr[0];
                        else
                           n.otp[r.addr[5:0]] = r.otp[r.addr[5:0]] & n.sr;
                     end
                     n.addr[6:0] = r.addr[6:0] + 7'h1;
                  end
                  else if (r.pcount < 9'(SFB_PAGE_BYTES))
                  begin
                     // core too slow: byte is lost and flagged, host cannot stall
                     if (fifo_in_ready)
                     begin
                        fifo_push = 1'b1;
                        n.addr[7:0] = r.addr[7:0] + 8'h1;
                        n.pcount = r.pcount + 9'h1;
                     end
                     else
                        n.overrun = 1'b1;
                  end
               end
            end
            ST_DONE:
            begin
               // clocks past the last byte count modulo 8; only a partial byte aborts
               n.bits = (r.bits == 5'h7) ? 5'h0 : r.bits + 5'h1;
            end
            default:
            begin
            end
         endcase
      end
      else if (fall_ok && r.st == ST_RDATA)
      begin
         n.drv = 1'b1;
         n.so_out = rbyte[~r.pos];
         if (r.cmd == SFB_OP_DUAL_RD)
         begin
            n.si_out = rbyte[~pos1];
            n.pos = r.pos + 3'h2;
         end
         else
            n.pos = pos1;
         if (n.pos == 3'h0)
         begin
            n.addr = r.addr + 24'h00_0001;
            n.rd_addr = r.rd_addr + 24'h00_0001;
         end
      end
      n.so_oe_n = ~(~csn & ~holdact & n.drv & n.st == ST_RDATA);
      n.si_oe_n = ~(~csn & ~holdact & n.drv & n.st == ST_RDATA & n.cmd == SFB_OP_DUAL_RD);
      n.standby = csn & ~core_busy;
   end

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         r <= '0;
         r.s1 <= SFB_SYNC_RST;
         r.s2 <= SFB_SYNC_RST;
         r.otp <= '1;
         r.so_oe_n <= 1'b1;
         r.si_oe_n <= 1'b1;
      end
      else
         r <= n;
   end

   sfb_fifo #(.WIDTH(SFB_ADDR_W + 8), .DEPTH(SFB_FIFO_DEPTH)) u_fifo (
      .core_clk(core_clk),
      .rst(rst),
      .in_valid(fifo_push),
      .in_ready(fifo_in_ready),
      .in_data({r.addr, n.sr}),
      .out_valid(prog_valid),
      .out_ready(prog_ready),
      .out_data({prog_addr, prog_data})
   );

   ////////////////////////////////////////////////////////////////////////////
   assign serial_in_pin_out = r.si_out;
   assign serial_in_pin_oe_n = r.si_oe_n;
   assign serial_out_pin_out = r.so_out;
   assign serial_out_pin_oe_n = r.so_oe_n;
   assign standby = r.standby;
   assign mem_rd_addr = r.rd_addr;
   assign erase_req = r.erase_req;
   assign erase_kind = r.erase_kind;
   assign erase_subsector = r.erase_sub;
   assign erase_fast = r.erase_fast;
   assign prog_commit = r.commit;
   assign prog_overrun = r.overrun;

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   sequence s_dual_rise;
      rise_ok && r.st == ST_WDATA && r.cmd == SFB_OP_DUAL_PG;
   endsequence

   chk_desel_hiz: assert property (csn |=> serial_out_pin_oe_n)
      else $error("output pin driven while deselected");
   chk_hold_hiz: assert property (holdact |=> serial_out_pin_oe_n && serial_in_pin_oe_n)
      else $error("pin driven during hold");
   chk_hold_freeze: assert property ((holdact && !r.csn_d) |=> $stable(r.st) && $stable(r.bits))
      else $error("transfer state moved during hold");
   chk_unarmed_idle: assert property (!r.armed |=> r.st == ST_IDLE)
      else $error("instruction started before first select fall");
   chk_erase_wel: assert property (erase_req |-> $past(r.wel))
      else $error("erase without write enable");
   chk_erase_align: assert property (erase_req |-> $past(r.bits) == 5'h0)
      else $error("erase after partial byte");
   chk_fast_bulk: assert property (erase_req && erase_kind == SFB_ER_BULK |->
      erase_fast == $past(r.s2[5]))
      else $error("fast bulk erase not following high voltage");
   chk_page_limit: assert property (fifo_push |-> r.pcount < 9'(SFB_PAGE_BYTES))
      else $error("more than a page accepted");
   chk_otp_lock: assert property (r.otp_locked |=> r.otp_locked && $stable(r.otp))
      else $error("locked one-time area changed");
   chk_out_fall: assert property ($changed(serial_out_pin_out) |-> $past(fall_ok))
      else $error("output bit changed without falling clock");
   chk_cmd_sample: assert property (rise_ok && r.st == ST_CMD |=> r.sr[0] == $past(r.s2[3]))
      else $error("instruction bit not sampled on rise");
   chk_dual_two: assert property (s_dual_rise |=>
      r.bits == (($past(r.bits) + 5'h2) & 5'h7))
      else $error("dual program not two bits per clock");
   chk_standby: assert property (standby |-> $past(csn) && !$past(core_busy))
      else $error("standby while selected or busy");
endmodule // sfb_spi

// ---- rtl/sfb_pkg.sv ----
package sfb_pkg;
   // array organisation
   localparam int SFB_ADDR_W = 24;
   localparam int SFB_SECTORS = 128;
   localparam int SFB_SUBS_PER_SECTOR = 16;
   localparam int SFB_SUBSECTORS = SFB_SECTORS * SFB_SUBS_PER_SECTOR;
   localparam int SFB_SUB_LSB = 12;
   localparam int SFB_SECT_LSB = 16;
   localparam int SFB_MEM_TOP = 22;
   localparam int SFB_PAGE_BYTES = 256;
   localparam int SFB_OTP_BYTES = 64;
   localparam int SFB_FIFO_DEPTH = 4;
   // instruction codes
   localparam logic [7:0] SFB_OP_NONE = 8'h00;
   localparam logic [7:0] SFB_OP_WR_EN = 8'h06;
   localparam logic [7:0] SFB_OP_READ = 8'h03;
   localparam logic [7:0] SFB_OP_DUAL_RD = 8'h3B;
   localparam logic [7:0] SFB_OP_OTP_RD = 8'h4B;
   localparam logic [7:0] SFB_OP_PP = 8'h02;
   localparam logic [7:0] SFB_OP_DUAL_PG = 8'hA2;
   localparam logic [7:0] SFB_OP_OTP_PG = 8'h42;
   localparam logic [7:0] SFB_OP_SSE = 8'h20;
   localparam logic [7:0] SFB_OP_SE = 8'hD8;
   localparam logic [7:0] SFB_OP_BE = 8'hC7;
   // erase kinds
   localparam logic [1:0] SFB_ER_SUB = 2'h0;
   localparam logic [1:0] SFB_ER_SECT = 2'h1;
   localparam logic [1:0] SFB_ER_BULK = 2'h2;
   // sync order: vpp, so, si, hold_n, cs_n, sclk
   localparam logic [5:0] SFB_SYNC_RST = 6'h04;
   typedef enum logic [2:0] {ST_IDLE, ST_CMD, ST_ADDR, ST_DUMMY, ST_RDATA, ST_WDATA, ST_DONE}
      sfb_state_t;
endpackage

// ---- tb/sfb_host.sv ----
`timescale 1ns/1ps
module sfb_host (
   // clock
   input wire logic core_clk,
   // host-driven pins
   output logic sclk,
   output logic cs_n,
   output logic hold_n,
   // device drive of the data pins
   input wire logic si_out,
   input wire logic si_oe_n,
   input wire logic so_out,
   input wire logic so_oe_n,
   // resolved data wires
   output logic si_wire,
   output logic so_wire
);
   logic si_drv = 1'b1;
   logic so_drv = 1'b0;
   logic si_en = 1'b1;
   logic so_en = 1'b0;
   logic flt;

   initial
   begin
      sclk = 1'b0; // mode 0, idle low
      cs_n = 1'b0;
      hold_n = 1'b1;
   end

   // undriven wire toggles so a stale bit never reads as good
   always @(posedge core_clk)
      flt <= (flt === 1'b0);
   assign si_wire = !si_oe_n ? si_out : (si_en ? si_drv : flt);
   assign so_wire = !so_oe_n ? so_out : (so_en ? so_drv : flt);

   ////////////////////////////////////////
   task automatic drive(input logic si_e, input logic so_e);
      @(posedge core_clk);
      si_en <= si_e;
      so_en <= so_e;
   endtask

   // one clock: 4 cycles low then 4 high, 160 ns
   task automatic bitx(input logic [1:0] d, output logic [1:0] q);
      @(posedge core_clk);
      sclk <= 1'b0;
      si_drv <= d[0];
      so_drv <= d[1];
      repeat (3) @(posedge core_clk);
      @(negedge core_clk);
      q = {so_wire, si_wire};
      @(posedge core_clk);
      sclk <= 1'b1; // data taken on rise
      repeat (3) @(posedge core_clk);
   endtask

   task automatic xbyte(input logic [7:0] tx, input logic dual, output logic [7:0] rx);
      logic [1:0] q;
      int i;
      rx = 8'h00;
      if (dual)
         for (i = 3; i >= 0; i--)
         begin
            bitx(tx[2*i+:2], q); // high bit of a pair on the output pin
            rx[2*i+:2] = q;
         end
      else
         for (i = 7; i >= 0; i--)
         begin
            bitx({1'b0, tx[i]}, q); // msb first
            rx[i] = q[1];
         end
   endtask

   task automatic frame_start();
      @(posedge core_clk);
      cs_n <= 1'b0;
      repeat (4) @(posedge core_clk);
   endtask

   task automatic frame_end();
      @(posedge core_clk);
      sclk <= 1'b0; // back to idle level before release
      repeat (4) @(posedge core_clk);
      cs_n <= 1'b1;
      si_en <= 1'b1;
      so_en <= 1'b0;
      repeat (8) @(posedge core_clk);
   endtask

   // only called while selected
   task automatic pause();
      @(posedge core_clk);
      hold_n <= 1'b0;
      repeat (5) @(posedge core_clk);
      sclk <= 1'b0;
      si_drv <= ~si_drv;
      repeat (4) @(posedge core_clk);
      sclk <= 1'b1;
      repeat (4) @(posedge core_clk);
   endtask

   task automatic resume();
      @(posedge core_clk);
      hold_n <= 1'b1;
      repeat (4) @(posedge core_clk);
   endtask
endmodule // sfb_host

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
module tb_top import sfb_pkg::*;;
   logic core_clk, rst, sclk, cs_n, hold_n, vpp_high, core_busy, standby;
   logic si_wire, si_out, si_oe_n, so_wire, so_out, so_oe_n;
   logic [SFB_SECTORS-1:0] sector_protect;
   logic [SFB_ADDR_W-1:0] mem_rd_addr, prog_addr;
   logic [7:0] mem_rd_data, prog_data;
   logic erase_req, erase_fast, prog_valid, prog_ready, prog_commit, prog_overrun;
   logic [1:0] erase_kind, er_k;
   logic [10:0] erase_subsector, er_s;
   logic er_f;
   int fail_count, checked, er_cnt, ov_cnt, cm_cnt, oe_lo;
   logic [31:0] pq[$];

   sfb_host sfb_host_i (.core_clk(core_clk), .sclk(sclk), .cs_n(cs_n), .hold_n(hold_n),
      .si_out(si_out), .si_oe_n(si_oe_n), .so_out(so_out), .so_oe_n(so_oe_n),
      .si_wire(si_wire), .so_wire(so_wire));

   sfb_spi sfb_spi_i (.core_clk(core_clk), .rst(rst), .sclk(sclk), .cs_n(cs_n),
      .hold_n(hold_n), .vpp_high(vpp_high), .serial_in_pin_in(si_wire),
      .serial_in_pin_out(si_out), .serial_in_pin_oe_n(si_oe_n),
      .serial_out_pin_in(so_wire), .serial_out_pin_out(so_out),
      .serial_out_pin_oe_n(so_oe_n), .core_busy(core_busy),
      .sector_protect(sector_protect), .standby(standby), .mem_rd_addr(mem_rd_addr),
      .mem_rd_data(mem_rd_data), .erase_req(erase_req), .erase_kind(erase_kind),
      .erase_subsector(erase_subsector), .erase_fast(erase_fast), .prog_valid(prog_valid),
      .prog_ready(prog_ready), .prog_addr(prog_addr), .prog_data(prog_data),
      .prog_commit(prog_commit), .prog_overrun(prog_overrun));

   initial
   begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end

   // array core stand-in and event capture
   always @(posedge core_clk)
   begin
      mem_rd_data <= mem_rd_addr[7:0] ^ 8'h3C;
      if (so_oe_n === 1'b0)
         oe_lo <= oe_lo + 1;
      if (erase_req === 1'b1)
      begin
         er_cnt <= er_cnt + 1;
         er_k <= erase_kind;
         er_s <= erase_subsector;
         er_f <= erase_fast;
      end
      if (prog_overrun === 1'b1)
         ov_cnt <= ov_cnt + 1;
      if (prog_commit === 1'b1)
         cm_cnt <= cm_cnt + 1;
      if (prog_valid === 1'b1 && prog_ready === 1'b1)
         pq.push_back({prog_addr, prog_data});
   end

   ////////////////////////////////////////
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp)
      begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic complete_run();
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic send(input logic [7:0] b);
      logic [7:0] r;
      sfb_host_i.xbyte(b, 1'b0, r);
   endtask

   task automatic head(input logic [7:0] op, input logic [23:0] a);
      logic [31:0] w;
      w = {op, a};
      sfb_host_i.frame_start();
      for (int i = 0; i < 4; i++)
         send(w[31-8*i-:8]);
   endtask

   task automatic write_en();
      sfb_host_i.frame_start();
      send(SFB_OP_WR_EN);
      sfb_host_i.frame_end();
   endtask

   task automatic wait_pops(input int n);
      for (int i = 0; i < 300 && pq.size() < n; i++)
         @(posedge core_clk);
      if (pq.size() < n)
      begin
         fail_count++;
         complete_run();
      end
   endtask

   ////////////////////////////////////////
   task automatic sc_select_and_hold();
      logic [7:0] r;
      head(SFB_OP_READ, 24'h00_0010);
      send(8'h00);
      sfb_host_i.frame_end();
      chk("drive before first select", 0, oe_lo);
      chk("standby idle", 1, standby);
      chk("out pin deselected", 1, so_oe_n);
      core_busy <= 1'b1;
      repeat (6) @(posedge core_clk);
      chk("standby while busy", 0, standby);
      core_busy <= 1'b0;
      head(SFB_OP_READ, 24'h00_12F0);
      chk("standby selected", 0, standby);
      sfb_host_i.xbyte(8'h00, 1'b0, r);
      chk("read byte0", 8'hF0 ^ 8'h3C, r);
      sfb_host_i.pause();
      chk("out pin in hold", 1, so_oe_n);
      chk("selected in hold", 0, standby);
      sfb_host_i.resume();
      sfb_host_i.xbyte(8'h00, 1'b0, r);
      chk("read after hold", 8'hF1 ^ 8'h3C, r);
      sfb_host_i.frame_end();
      chk("out pin released", 1, so_oe_n);
   endtask

   task automatic sc_dual_read();
      logic [7:0] r;
      head(SFB_OP_DUAL_RD, 24'h00_0040);
      send(8'h00);
      sfb_host_i.drive(1'b0, 1'b0);
      sfb_host_i.xbyte(8'h00, 1'b1, r);
      chk("in pin driven", 0, si_oe_n);
      chk("dual byte0", 8'h40 ^ 8'h3C, r);
      sfb_host_i.xbyte(8'h00, 1'b1, r);
      chk("dual byte1", 8'h41 ^ 8'h3C, r);
      sfb_host_i.frame_end();
   endtask

   task automatic erase(input logic [7:0] op, input logic [23:0] a, input int n,
      input logic [1:0] kind, input logic [10:0] sub, input logic fast);
      int c0;
      c0 = er_cnt;
      write_en();
      sfb_host_i.frame_start();
      send(op);
      if (op != SFB_OP_BE)
         for (int i = 2; i >= 0; i--)
            send(a[8*i+:8]);
      sfb_host_i.frame_end();
      chk("erase count", n, er_cnt - c0);
      if (n == 1)
         chk("erase kind", {kind, fast}, {er_k, er_f});
      if (n == 1 && op != SFB_OP_BE)
         chk("erase subsector", sub, er_s);
   endtask

   task automatic sc_erase();
      logic [1:0] q;
      int c0;
      erase(SFB_OP_SSE, 24'h7F_F000, 1, SFB_ER_SUB, 11'h7FF, 1'b0);
      sector_protect[7'h12] <= 1'b1;
      erase(SFB_OP_SE, 24'h12_3456, 0, SFB_ER_SECT, 11'h120, 1'b0);
      erase(SFB_OP_BE, 24'h00_0000, 0, SFB_ER_BULK, 11'h000, 1'b0);
      sector_protect <= 128'h1 << 7'h13;
      erase(SFB_OP_SE, 24'h12_3456, 1, SFB_ER_SECT, 11'h120, 1'b0);
      sector_protect <= '0;
      erase(SFB_OP_BE, 24'h00_0000, 1, SFB_ER_BULK, 11'h000, 1'b0);
      vpp_high <= 1'b1;
      erase(SFB_OP_BE, 24'h00_0000, 1, SFB_ER_BULK, 11'h000, 1'b1);
      vpp_high <= 1'b0;
      c0 = er_cnt;
      write_en();
      head(SFB_OP_SSE, 24'h00_1000);
      repeat (4) sfb_host_i.bitx(2'b01, q);
      sfb_host_i.frame_end();
      chk("erase after abort", 0, er_cnt - c0);
   endtask

   task automatic sc_program();
      logic [7:0] r;
      int c0;
      prog_ready <= 1'b0;
      write_en();
      head(SFB_OP_PP, 24'h00_00F0);
      for (int i = 0; i < 5; i++)
         send(8'h10 + 8'(i));
      sfb_host_i.frame_end();
      chk("overrun on full buffer", 1, ov_cnt);
      prog_ready <= 1'b1;
      wait_pops(4);
      for (int i = 0; i < 4; i++)
         chk("page byte", {24'h00_00F0 + 24'(i), 8'h10 + 8'(i)}, pq[i]);
      pq.delete();
      c0 = cm_cnt;
      write_en();
      head(SFB_OP_DUAL_PG, 24'h00_00FF);
      sfb_host_i.drive(1'b1, 1'b1);
      sfb_host_i.xbyte(8'hC3, 1'b1, r);
      sfb_host_i.xbyte(8'h5A, 1'b1, r);
      sfb_host_i.frame_end();
      wait_pops(2);
      chk("dual byte0", {24'h00_00FF, 8'hC3}, pq[0]);
      chk("dual byte wraps", {24'h00_0000, 8'h5A}, pq[1]);
      chk("commit", 1, cm_cnt - c0);
      pq.delete();
   endtask

   task automatic otp(input logic wr, input logic [23:0] a, input logic [7:0] d,
      output logic [7:0] r);
      if (wr)
         write_en();
      head(wr ? SFB_OP_OTP_PG : SFB_OP_OTP_RD, a);
      sfb_host_i.xbyte(d, 1'b0, r);
      if (!wr)
         sfb_host_i.xbyte(8'h00, 1'b0, r);
      sfb_host_i.frame_end();
   endtask

   task automatic sc_otp();
      logic [7:0] r;
      otp(1'b1, 24'h00_0005, 8'hA5, r);
      otp(1'b0, 24'h00_0005, 8'h00, r);
      chk("otp byte", 8'hA5, r);
      otp(1'b0, 24'h00_0040, 8'h00, r);
      chk("otp unlocked", 1, r[0]);
      otp(1'b1, 24'h00_0040, 8'hFE, r);
      otp(1'b1, 24'h00_0006, 8'h00, r);
      otp(1'b0, 24'h00_0006, 8'h00, r);
      chk("otp write refused", 8'hFF, r);
      otp(1'b0, 24'h00_0040, 8'h00, r);
      chk("otp locked", 0, r[0]);
   endtask

   ////////////////////////////////////////
   initial
   begin
      rst = 1'b1;
      vpp_high = 1'b0;
      core_busy = 1'b0;
      sector_protect = '0;
      prog_ready = 1'b1;
      repeat (5) @(posedge core_clk);
      rst <= 1'b0;
      repeat (3) @(posedge core_clk);
      sc_select_and_hold();
      sc_dual_read();
      sc_erase();
      sc_program();
      sc_otp();
      complete_run();
   end

   // a hang ends the run as a failure
   initial
   begin
      repeat (100000) @(posedge core_clk);
      fail_count++;
      complete_run();
   end
endmodule // tb_top
